//--- rtl/sbd_pkg.sv
// constants and carrier types for the serial baud divisor
// assumes one 100 MHz system clock and a 40 MHz crystal reference
package sbd_pkg;

    // system clock and crystal rate, in Hz
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned XTAL_HZ    = 40_000_000;
    // fixed prescale from crystal to prescaled reference
    localparam int unsigned PRESCALE   = 32;
    localparam int unsigned PRE_REF_HZ = XTAL_HZ / PRESCALE;
    // fastest line rate the serial side supports, in baud
    localparam int unsigned MAX_BAUD   = 625_000;
    // crystal enable by phase accumulator: XTAL_HZ / CLK_HZ = step / mod
    localparam int unsigned PHASE_UNIT = 10_000_000;
    localparam logic [3:0]  PHASE_STEP = 4'(XTAL_HZ / PHASE_UNIT);
    localparam logic [3:0]  PHASE_MOD  = 4'(CLK_HZ / PHASE_UNIT);

    // widths
    localparam int unsigned RATE_W = 32;
    localparam int unsigned DIV_W  = 21;
    localparam int unsigned NUM_W  = RATE_W + 1;
    localparam int unsigned PRE_W  = 5;

    localparam logic [DIV_W-1:0]  DIV_MAX     = {DIV_W{1'b1}};
    localparam logic [DIV_W-1:0]  DIV_MIN     = 21'h000001;
    // divisor after reset: 9600 baud, round(1250000 / 9600)
    localparam logic [DIV_W-1:0]  DIV_RESET   = 21'h000082;
    localparam logic [RATE_W-1:0] RATE_RESET  = 32'h00002580;
    localparam logic [NUM_W-1:0]  PRE_REF_NUM = NUM_W'(PRE_REF_HZ);
    localparam logic [RATE_W-1:0] MAX_RATE    = RATE_W'(MAX_BAUD);
    localparam logic [PRE_W-1:0]  PRE_LAST    = PRE_W'(PRESCALE - 1);
    localparam logic [5:0]        DIV_STEPS   = 6'(NUM_W);
    // tolerance: deviation below 1/50 of the achieved rate product
    localparam logic [63:0]       TOL_RECIP   = 64'h0000000000000032;

    // configuration request from the owning logic
    typedef struct packed {
        logic              load;
        logic [RATE_W-1:0] requested_line_rate;
    } sbd_cfg_t;

    // status of the generator
    typedef struct packed {
        logic             busy;
        logic             within_tolerance;
        logic             above_max_rate;
        logic [DIV_W-1:0] divisor;
    } sbd_status_t;

    typedef enum logic [1:0] {
        SBD_IDLE,
        SBD_DIVIDE,
        SBD_CHECK
    } sbd_state_t;

endpackage : sbd_pkg

//--- rtl/sbd_baud_divisor.sv
// baud rate generator: rounds a requested rate to a crystal divisor
// and emits one clock-wide pulse per bit period at the achieved rate.
// assumes cfg_in comes from logic on clk_in and needs no synchroniser.
`timescale 1ns/1ps

module sbd_baud_divisor (
    input  wire logic                clk_in,
    input  wire logic                reset_n_in,
    input  wire logic                clk_en_in,
    input  wire sbd_pkg::sbd_cfg_t   cfg_in,
    output logic                     cfg_ready_out,
    output sbd_pkg::sbd_status_t     status_out,
    output logic                     bit_tick_out
);
    import sbd_pkg::*;

    sbd_state_t          state;
    // crystal enable, prescaler and bit timing
    logic [3:0]          phase;
    logic                xtal_en;
    logic [PRE_W-1:0]    pre_cnt;
    logic                pre_tick;
    logic [DIV_W-1:0]    div_cnt;
    logic [DIV_W-1:0]    divisor;
    logic                div_commit;
    // rounding divider datapath
    logic [RATE_W-1:0]   rate;
    logic [NUM_W-1:0]    num;
    logic [NUM_W-1:0]    den;
    logic [NUM_W:0]      rem;
    logic [NUM_W-1:0]    quo;
    logic [5:0]          step_cnt;
    // status flags and tolerance arithmetic
    logic                within_tol;
    logic                above_max;
    logic [NUM_W:0]      next_rem;
    logic                rem_fits;
    logic [DIV_W-1:0]    next_divisor;
    logic [63:0]         product;
    logic [63:0]         deviation;

    // a new request is only taken while no division is running
    // limitation: a load while busy is dropped with no indication
    assign cfg_ready_out = (state == SBD_IDLE);

    // crystal enable at 40 MHz
    // fractional accumulator keeps the long-run rate exact on 100 MHz
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase   <= 4'h0;
            xtal_en <= 1'b0;
        end else if (clk_en_in) begin
            if (phase + PHASE_STEP >= PHASE_MOD) begin
                phase   <= phase + PHASE_STEP - PHASE_MOD;
                xtal_en <= 1'b1;
            end else begin
                phase   <= phase + PHASE_STEP;
                xtal_en <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_cnt  <= '0;
            pre_tick <= 1'b0;
        end else if (clk_en_in) begin
            pre_tick <= xtal_en && (pre_cnt == PRE_LAST);
            if (xtal_en) begin
                pre_cnt <= pre_cnt + 1'b1; // wraps at 32 by width
            end
        end
    end

    // bit period from divisor
    // restarting on commit starts the new count at once, giving one odd-length period after a change
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_cnt      <= DIV_RESET - DIV_MIN;
            bit_tick_out <= 1'b0;
        end else if (clk_en_in) begin
            bit_tick_out <= 1'b0;
            if (div_commit) begin
                div_cnt <= divisor - DIV_MIN;
            end else if (pre_tick) begin
                if (div_cnt == '0) begin
                    div_cnt      <= divisor - DIV_MIN;
                    bit_tick_out <= 1'b1;
                end else begin
                    div_cnt <= div_cnt - 1'b1;
                end
            end
        end
    end

    // one restoring step of the divider
    always_comb begin
        next_rem = {rem[NUM_W-1:0], num[NUM_W-1]};
        rem_fits = (next_rem >= {1'b0, den});
    end

    // a zero rate divides by zero and saturates here
    // saturate and clamp quotient
    always_comb begin
        if (quo > NUM_W'(DIV_MAX)) begin
            next_divisor = DIV_MAX;
        end else if (quo == '0) begin
            next_divisor = DIV_MIN;
        end else begin
            next_divisor = quo[DIV_W-1:0];
        end
    end

    // deviation test against achieved rate
    // |ref - k*r| * 50 < k*r  is  |ref/k - r| / r < 2 percent
    always_comb begin
        product = 64'(divisor) * 64'(rate);
        if (product > 64'(PRE_REF_NUM)) begin
            deviation = product - 64'(PRE_REF_NUM);
        end else begin
            deviation = 64'(PRE_REF_NUM) - product;
        end
    end

    // rounded division sequence
    // round(a/b) half up is floor((2a + b) / 2b); 33 steps, one per cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state      <= SBD_IDLE;
            rate       <= RATE_RESET;
            num        <= '0;
            den        <= '0;
            rem        <= '0;
            quo        <= '0;
            step_cnt   <= 6'h00;
            divisor    <= DIV_RESET;
            div_commit <= 1'b0;
        end else if (clk_en_in) begin
            div_commit <= 1'b0;
            case (state)
                SBD_IDLE: begin
                    // any integer rate accepted
                    // operands doubled so one floor rounds half up
                    if (cfg_in.load) begin
                        rate     <= cfg_in.requested_line_rate;
                        num      <= {PRE_REF_NUM[NUM_W-2:0], 1'b0}
                                    + NUM_W'(cfg_in.requested_line_rate);
                        den      <= {cfg_in.requested_line_rate, 1'b0};
                        rem      <= '0;
                        quo      <= '0;
                        step_cnt <= DIV_STEPS;
                        state    <= SBD_DIVIDE;
                    end
                end
                SBD_DIVIDE: begin
                    // a zero rate makes every step fit: slowest divisor
                    num <= {num[NUM_W-2:0], 1'b0};
                    quo <= {quo[NUM_W-2:0], rem_fits};
                    if (rem_fits) begin
                        rem <= next_rem - {1'b0, den};
                    end else begin
                        rem <= next_rem;
                    end
                    step_cnt <= step_cnt - 1'b1;
                    if (step_cnt == 6'h01) begin
                        state <= SBD_CHECK;
                    end
                end
                SBD_CHECK: begin
                    // exact divisors 4 and 2 pass unchanged
                    divisor    <= next_divisor;
                    div_commit <= 1'b1;
                    state      <= SBD_IDLE;
                end
                default: begin
                    state <= SBD_IDLE;
                end
            endcase
        end
    end

    // status flags follow the divisor now in use
    // tolerance flag on commit
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            within_tol <= 1'b1;
        end else if (clk_en_in && div_commit) begin
            within_tol <= (deviation * TOL_RECIP) < product;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            above_max <= 1'b0;
        end else if (clk_en_in && div_commit) begin
            above_max <= (rate > MAX_RATE);
        end
    end

    // status carrier, one driver for the whole struct
    always_comb begin
        status_out.busy             = (state != SBD_IDLE);
        status_out.within_tolerance = within_tol;
        status_out.above_max_rate   = above_max;
        status_out.divisor          = divisor;
    end

endmodule // sbd_baud_divisor

//--- bench/sbd_props.sv
// checker on the baud divisor top ports
// assumes the bench keeps clk_en_in high while loads run
`timescale 1ns/1ps
module sbd_props (
    input wire logic                 clk_in,
    input wire logic                 reset_n_in,
    input wire logic                 clk_en_in,
    input wire sbd_pkg::sbd_cfg_t    cfg_in,
    input wire logic                 cfg_ready_out,
    input wire sbd_pkg::sbd_status_t status_out,
    input wire logic                 bit_tick_out
);
    import sbd_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // expected divisor: half rounds up, zero lifted to one
    logic [33:0] quot;
    logic [20:0] exp_div;
    logic        over;
    assign quot = (34'(PRE_REF_NUM) * 34'h2 + 34'(cfg_in.requested_line_rate))
        / 34'({cfg_in.requested_line_rate, 1'b0});
    // a zero rate takes the slowest divisor
    assign exp_div = (cfg_in.requested_line_rate == '0) ? DIV_MAX :
        (quot == 34'h0) ? 21'h1 : 21'(quot);
    assign over = cfg_in.requested_line_rate > MAX_RATE;
    sequence s_take;
        clk_en_in && cfg_ready_out && cfg_in.load;
    endsequence
    sequence s_done;
        ##34 status_out.busy ##1 cfg_ready_out;
    endsequence
    take_busy_a: assert property (s_take |=> status_out.busy)
        else $error("load not taken");
    busy_refuse_a: assert property (status_out.busy |-> !cfg_ready_out)
        else $error("ready while busy");
    load_time_a: assert property (s_take |-> s_done)
        else $error("load not done in 35 cycles");
    div_value_a: assert property (s_take |-> ##35
        status_out.divisor == $past(exp_div, 35)) else $error("bad divisor");
    rate_over_a: assert property (s_take |-> ##36
        status_out.above_max_rate == $past(over, 36)) else $error("bad max");
    div_nonzero_a: assert property (status_out.divisor != '0)
        else $error("zero divisor");
    div_hold_a: assert property (!status_out.busy &&
        !$past(status_out.busy) |-> $stable(status_out.divisor))
        else $error("divisor moved while idle");
    tick_single_a: assert property (bit_tick_out |=> !bit_tick_out)
        else $error("tick wider than one cycle");
endmodule // sbd_props

bind sbd_baud_divisor sbd_props i_sbd_props (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .cfg_in(cfg_in),
    .cfg_ready_out(cfg_ready_out), .status_out(status_out),
    .bit_tick_out(bit_tick_out));

//--- bench/sbd_serial_peer.sv
// serial peer model: times the bit ticks it samples on
// assumes ticks come from the device on the same clock
`timescale 1ns/1ps
module sbd_serial_peer (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        bit_tick_in,
    output logic [31:0]      gap_out,
    output logic [31:0]      ticks_out
);
    logic [31:0] run;
    // one sample per tick
    // gap is the peer's view of one bit time
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run <= 32'h0;
            gap_out <= 32'h0;
            ticks_out <= 32'h0;
        end else if (bit_tick_in) begin
            gap_out <= run + 32'h1;
            run <= 32'h0;
            ticks_out <= ticks_out + 32'h1;
        end else begin
            run <= run + 32'h1;
        end
    end
endmodule // sbd_serial_peer

//--- bench/sbd_baud_divisor_bench.sv
// self-checking bench for the baud divisor
// assumes the checker binds itself to the design
`timescale 1ns/1ps
module sbd_baud_divisor_bench;
    import sbd_pkg::*;
    logic        clk, rst_n, en, tick, rdy;
    sbd_cfg_t    cfg;
    sbd_status_t st;
    logic [31:0] gap, nt;
    int          n_mismatch, checks_done, seed;
    sbd_baud_divisor i_sbd_baud_divisor (.clk_in(clk), .reset_n_in(rst_n),
        .clk_en_in(en), .cfg_in(cfg), .cfg_ready_out(rdy),
        .status_out(st), .bit_tick_out(tick));
    sbd_serial_peer i_sbd_serial_peer (.clk_in(clk), .reset_n_in(rst_n),
        .bit_tick_in(tick), .gap_out(gap), .ticks_out(nt));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // nearest divisor, half up, never zero; zero rate is slowest
    function automatic logic [31:0] want_div(logic [31:0] r);
        logic [63:0] q;
        if (r == 32'h0)
            return 32'(DIV_MAX);
        q = (64'(PRE_REF_HZ) * 64'h2 + 64'(r)) / (64'(r) * 64'h2);
        return (q == 64'h0) ? 32'h1 : q[31:0];
    endfunction
    // deviation against the achieved product, under one fiftieth
    function automatic logic want_tol(logic [31:0] r);
        logic [63:0] kr, rf;
        kr = 64'(want_div(r)) * 64'(r);
        rf = 64'(PRE_REF_HZ);
        return ((kr > rf ? kr - rf : rf - kr) * 64'h32) < kr;
    endfunction
    // bounded wait; a hang ends the run as a failure
    task automatic wait_rdy;
        for (int i = 0; i < 60 && rdy !== 1'b1; i++)
            @(negedge clk);
        if (rdy !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    // junk keeps load high with another rate while busy
    task automatic load(logic [31:0] r, bit junk);
        wait_rdy();
        @(posedge clk);
        cfg <= '{1'b1, r};
        @(posedge clk);
        cfg <= '{junk, r + 32'h1};
        repeat (3) @(posedge clk);
        cfg <= '{1'b0, r};
        @(negedge clk);
        wait_rdy();
        @(negedge clk);
        chk("divisor", want_div(r), 32'(st.divisor));
        chk("above_max", 32'(r > MAX_RATE), 32'(st.above_max_rate));
        chk("tolerance", 32'(want_tol(r)), 32'(st.within_tolerance));
    endtask
    // spacing of two fresh ticks against divisor times 80 clocks
    task automatic tick_gap(logic [31:0] d);
        logic [31:0] n0;
        n0 = nt;
        for (int i = 0; i < d * 200 && nt < n0 + 32'h2; i++)
            @(negedge clk);
        if (nt < n0 + 32'h2) begin
            n_mismatch++;
            end_sim();
        end
        chk("tick_gap", 32'h1, 32'(gap + 32'h1 >= d * 32'h50 &&
            gap <= d * 32'h50 + 32'h1));
    endtask
    // clock enable low: no tick, no load taken, divisor held
    task automatic freeze(logic [31:0] d);
        logic [31:0] n0;
        for (int i = 0; i < 400 && tick !== 1'b1; i++)
            @(negedge clk);
        if (tick !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        @(posedge clk);
        en  <= 1'b0;
        cfg <= '{1'b1, 32'h2580};
        @(negedge clk);
        n0 = nt;
        repeat (200) @(posedge clk);
        @(negedge clk);
        chk("frozen_ticks", n0, nt);
        chk("frozen_rdy", 32'h1, 32'(rdy));
        chk("frozen_div", d, 32'(st.divisor));
        @(posedge clk);
        en  <= 1'b1;
        cfg <= '{1'b0, 32'h2580};
        repeat (2) @(negedge clk);
        chk("frozen_load", 32'h0, 32'(st.busy));
    endtask
    // corner rates; the widest comes last so the freeze test ticks fast
    logic [31:0] cor [12] = '{32'h0, 32'h1, 32'h2580, 32'h9600, 32'hF424,
        32'h1C200, 32'h4C4B4, 32'h98968, 32'h98969, 32'h2625A0,
        32'h2DC6C0, 32'hFFFFFFFF};
    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        cfg = '0;
        seed = 98;
        n_mismatch = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset_div", want_div(RATE_RESET), 32'(st.divisor));
        chk("reset_rdy", 32'h1, 32'(rdy));
        chk("reset_tol", 32'(want_tol(RATE_RESET)),
            32'(st.within_tolerance));
        chk("reset_max", 32'h0, 32'(st.above_max_rate));
        $display("test reset done");
        // corners: exact rates, limit, above limit, widest rate
        foreach (cor[k]) begin
            load(cor[k], k[0]);
            if (want_div(cor[k]) < 32'h20)
                tick_gap(want_div(cor[k]));
            $display("test corner %0d done", k);
        end
        freeze(want_div(32'hFFFFFFFF));
        $display("test freeze done");
        repeat (20)
            load(32'($unsigned($random(seed))) % 32'hAAE60 + 32'h1, 1'b0);
        $display("test random done");
        end_sim();
    end
endmodule // sbd_baud_divisor_bench
